// ==== design/fis_pkg.sv ====
// Functional notes
// R1: command irq requested while command-complete flag and its enable are both set
// R2: ecc double fault on a read sets the double-fault flag, own enable
// R3: ecc single fault on a read sets the single-fault flag, own enable
// R4: one error irq from both fault flags, each gated by its enable
// R5: wait mode leaves every flash activity running unchanged
// R6: enabled command-complete irq can wake the cpu from wait
// R7: stop entry granted only after a running command has finished
// R8: reset sequence loads the security register from the security byte
// R9: a newly programmed security byte takes effect only after next reset
// R10: backdoor key is four 16-bit words at a fixed flash range
// R11: key verify compares four words, only when the key-enable field allows
// R12: matching keys force the security bits to the unsecured code
// R13: all-zeros and all-ones words never count as valid keys
// R14: flash reads return invalid data while key verify runs
// R15: after a mismatch every key verify is refused until reset
// R16: key verify leaves security byte, keys and protection untouched
// R17: debug host erases and verifies all blocks in special single chip mode
// R18: both arrays verified erased in special mode unsecures, enables debug
// R19: irq outputs stay up while flag and enable are set, drop on clear
// R20: command-complete stays clear in reset sequence, command writes ignored
// R21: double fault in reset sequence sets both error bits, secured fallback
package fis_pkg;
	localparam int REG_AW = 4;
	localparam int REG_DW = 16;
	localparam logic [3:0] REG_CFG = 4'h0;
	localparam logic [3:0] REG_ERR_CFG = 4'h1;
	localparam logic [3:0] REG_STAT = 4'h2;
	localparam logic [3:0] REG_ERR_STAT = 4'h3;
	localparam logic [3:0] REG_SEC = 4'h4;
	localparam logic [3:0] REG_CMD = 4'h5;
	localparam logic [3:0] REG_KEY0 = 4'h6;
	localparam logic [3:0] REG_KEY3 = 4'h9;
	localparam int CFG_CMD_COMPLETE_IRQ_EN_BIT = 7;
	localparam int STAT_CMD_COMPLETE_FLAG_BIT = 7;
	localparam int STAT_ACC_BIT = 5;
	localparam int ERR_DF_BIT = 1;
	localparam int ERR_SF_BIT = 0;
	localparam int KEY_ENABLE_FIELD_MSB = 7;
	localparam int KEY_ENABLE_FIELD_LSB = 6;
	localparam logic [1:0] KEY_ENABLE_FIELD_ENABLED = 2'h2;
	localparam logic [1:0] SEC_UNSECURED = 2'h2;
	localparam logic [7:0] SEC_FALLBACK = 8'hFF;
	localparam logic [1:0] ERROR_STATUS_BITS_BOTH = 2'h3;
	localparam logic [17:0] ADDR_KEY_BASE = 18'h3FF00;
	localparam logic [17:0] ADDR_SEC_BYTE = 18'h3FF0F;
	localparam int KEY_WORDS = 4;
	localparam logic [2:0] RS_LAST_IDX = 3'h4;
	localparam logic [15:0] KEY_ZERO = 16'h0000;
	localparam logic [15:0] KEY_ONES = 16'hFFFF;
	localparam logic [7:0] CMD_VERIFY_KEY = 8'h01;
	localparam logic [7:0] CMD_ERASE_VERIFY_ALL = 8'h02;
	typedef enum logic [2:0]
	{
		ST_RS_REQ = 3'b000,
		ST_RS_CAP = 3'b001,
		ST_IDLE = 3'b010,
		ST_OP = 3'b011,
		ST_KEY = 3'b100
	} fis_state_t;
endpackage : fis_pkg

// ==== design/fis_irq_gate.sv ====
`timescale 1ns/100ps
module fis_irq_gate
	import fis_pkg::*;
#(
	parameter int N = 1
)
(
	input wire logic [N-1:0] flags,
	input wire logic [N-1:0] enables,
	output logic irq
);
	// level request, follows flag and enable with no memory of its own
	assign irq = |(flags & enables); // see R19
endmodule : fis_irq_gate

// ==== design/fis_key_word.sv ====
`timescale 1ns/100ps
module fis_key_word
	import fis_pkg::*;
(
	input wire logic [15:0] stored,
	input wire logic [15:0] given,
	output logic ok
);
	logic stored_legal;
	// an erased or zeroed key slot must never open the backdoor
	assign stored_legal = (stored != KEY_ZERO) && (stored != KEY_ONES); // see R13
	assign ok = stored_legal && (stored == given);
endmodule : fis_key_word

// ==== design/fis_flash_ctl.sv ====
`timescale 1ns/100ps
module fis_flash_ctl
	import fis_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [REG_AW-1:0] reg_addr,
	input wire logic [REG_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [REG_DW-1:0] reg_rdata,
	output logic nvm_rd,
	output logic [17:0] nvm_addr,
	input wire logic [15:0] nvm_rdata,
	input wire logic nvm_ecc_dbl,
	input wire logic ecc_sgl_evt,
	input wire logic ecc_dbl_evt,
	output logic op_start,
	output logic [7:0] op_cmd,
	input wire logic op_done,
	input wire logic [1:0] op_err,
	input wire logic op_erased,
	input wire logic ssc_mode,
	input wire logic stop_req,
	output logic stop_ack,
	output logic irq_cmd,
	output logic irq_err,
	output logic wake_req,
	output logic read_blank,
	output logic [1:0] sec_state,
	output logic dbg_all_en
);
	fis_state_t state_ff;
	fis_state_t nxt_state;
	logic [2:0] rs_idx_ff;
	logic rs_fault_ff;
	logic [15:0] key_store_ff [KEY_WORDS];
	logic [15:0] key_given_ff [KEY_WORDS];
	logic [KEY_WORDS-1:0] word_ok;
	logic [7:0] sec_ff;
	logic cmd_complete_irq_en_ff;
	logic double_fault_irq_en_ff;
	logic single_fault_irq_en_ff;
	logic cmd_complete_flag_ff;
	logic nxt_cmd_complete_flag;
	logic acc_ff;
	logic nxt_acc;
	logic [1:0] error_status_bits_ff;
	logic [1:0] nxt_error_status_bits;
	logic double_fault_flag_ff;
	logic nxt_double_fault_flag;
	logic single_fault_flag_ff;
	logic nxt_single_fault_flag;
	logic [7:0] cmd_ff;
	logic key_lock_ff;
	logic [REG_DW-1:0] rdata_ff;
	logic [REG_DW-1:0] rd_mux;

	// decode
	wire wr_cfg = reg_wr && (reg_addr == REG_CFG);
	wire wr_err_cfg = reg_wr && (reg_addr == REG_ERR_CFG);
	wire wr_stat = reg_wr && (reg_addr == REG_STAT);
	wire wr_err_stat = reg_wr && (reg_addr == REG_ERR_STAT);
	wire cmd_open = cmd_complete_flag_ff; // see R20
	wire wr_cmd = reg_wr && (reg_addr == REG_CMD) && cmd_open;
	wire key_hit = (reg_addr >= REG_KEY0) && (reg_addr <= REG_KEY3);
	wire wr_key = reg_wr && key_hit && cmd_open;
	wire [1:0] key_sel = 2'(reg_addr - REG_KEY0);

	wire launch = wr_stat && reg_wdata[STAT_CMD_COMPLETE_FLAG_BIT] && cmd_complete_flag_ff
		&& (state_ff == ST_IDLE);
	wire is_key = (cmd_ff == CMD_VERIFY_KEY);
	wire key_enable_field_ok = (sec_ff[KEY_ENABLE_FIELD_MSB:KEY_ENABLE_FIELD_LSB] == KEY_ENABLE_FIELD_ENABLED);
	wire key_refuse = launch && is_key
		&& (key_lock_ff || !key_enable_field_ok); // see R11 see R15
	wire go_key = launch && is_key && !key_refuse;
	wire go_op = launch && !is_key;
	wire key_fin = (state_ff == ST_KEY);
	wire key_match = &word_ok; // see R11
	wire rs_cap = (state_ff == ST_RS_CAP);
	wire rs_last = (rs_idx_ff == RS_LAST_IDX);
	wire rs_done = rs_cap && rs_last;
	wire rs_bad = rs_fault_ff || (rs_cap && nvm_ecc_dbl);
	wire op_fin = (state_ff == ST_OP) && op_done;
	// the host owns the erase sequence; only the final verify is judged here
	wire eva_unsec = op_fin && (cmd_ff == CMD_ERASE_VERIFY_ALL)
		&& op_erased && ssc_mode; // see R17 see R18

	// key words at even addresses, security byte is the odd low byte
	assign nvm_rd = (state_ff == ST_RS_REQ);
	assign nvm_addr = rs_last ? {ADDR_SEC_BYTE[17:1], 1'b0}
		: ADDR_KEY_BASE + {15'h0000, rs_idx_ff[1:0], 1'b0}; // see R10

	genvar gi;
	generate
		for (gi = 0; gi < KEY_WORDS; gi++)
		begin : g_key
			fis_key_word u_word (
				.stored(key_store_ff[gi]),
				.given(key_given_ff[gi]),
				.ok(word_ok[gi])
			);
		end
	endgenerate

	// hardware set beats software clear on every flag
	assign nxt_cmd_complete_flag = (cmd_complete_flag_ff && !(go_key || go_op))
		|| rs_done || op_fin || key_fin; // see R20
	assign nxt_acc = (acc_ff && !launch) || key_refuse
		|| (key_fin && !key_match);
	assign nxt_double_fault_flag = (double_fault_flag_ff && !(wr_err_stat && reg_wdata[ERR_DF_BIT]))
		|| ecc_dbl_evt; // see R2
	assign nxt_single_fault_flag = (single_fault_flag_ff && !(wr_err_stat && reg_wdata[ERR_SF_BIT]))
		|| ecc_sgl_evt; // see R3
	assign nxt_error_status_bits = (rs_done && rs_bad) ? ERROR_STATUS_BITS_BOTH // see R21
		: launch ? 2'h0
		: op_fin ? op_err
		: error_status_bits_ff;

	// wait mode has no input here: nothing in the engine can pause
	always_comb
	begin
		case (state_ff)
			ST_RS_REQ: nxt_state = ST_RS_CAP;
			ST_RS_CAP: nxt_state = rs_last ? ST_IDLE : ST_RS_REQ;
			ST_IDLE: nxt_state = go_key ? ST_KEY
				: go_op ? ST_OP : ST_IDLE; // see R5
			ST_OP: nxt_state = op_done ? ST_IDLE : ST_OP;
			ST_KEY: nxt_state = ST_IDLE;
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_ff <= ST_RS_REQ;
			rs_idx_ff <= 3'h0;
			rs_fault_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			rs_idx_ff <= rs_cap ? rs_idx_ff + 3'h1 : rs_idx_ff;
			rs_fault_ff <= rs_bad;
		end
	end

	// keys only written by the reset load, never by a command
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < KEY_WORDS; i++)
			begin
				key_store_ff[i] <= KEY_ONES;
				key_given_ff[i] <= KEY_ZERO;
			end
		end
		else
		begin
			if (rs_cap && !rs_last)
				key_store_ff[rs_idx_ff[1:0]] <= nvm_rdata; // see R16
			if (wr_key)
				key_given_ff[key_sel] <= reg_wdata;
		end
	end

	// loaded once per reset; programming the byte later changes nothing
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			sec_ff <= SEC_FALLBACK;
		else if (rs_done)
			sec_ff <= rs_bad ? SEC_FALLBACK : nvm_rdata[7:0]; // see R8 see R9
		else if ((key_fin && key_match) || eva_unsec)
			sec_ff[1:0] <= SEC_UNSECURED; // see R12 see R18
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			key_lock_ff <= 1'b0;
		else if (key_fin && !key_match)
			key_lock_ff <= 1'b1; // see R15
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cmd_complete_irq_en_ff <= 1'b0;
			double_fault_irq_en_ff <= 1'b0;
			single_fault_irq_en_ff <= 1'b0;
			cmd_ff <= 8'h00;
		end
		else
		begin
			if (wr_cfg)
				cmd_complete_irq_en_ff <= reg_wdata[CFG_CMD_COMPLETE_IRQ_EN_BIT];
			if (wr_err_cfg)
			begin
				double_fault_irq_en_ff <= reg_wdata[ERR_DF_BIT];
				single_fault_irq_en_ff <= reg_wdata[ERR_SF_BIT];
			end
			if (wr_cmd)
				cmd_ff <= reg_wdata[7:0];
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cmd_complete_flag_ff <= 1'b0;
			acc_ff <= 1'b0;
			error_status_bits_ff <= 2'h0;
			double_fault_flag_ff <= 1'b0;
			single_fault_flag_ff <= 1'b0;
		end
		else
		begin
			cmd_complete_flag_ff <= nxt_cmd_complete_flag;
			acc_ff <= nxt_acc;
			error_status_bits_ff <= nxt_error_status_bits;
			double_fault_flag_ff <= nxt_double_fault_flag;
			single_fault_flag_ff <= nxt_single_fault_flag;
		end
	end

	always_comb
	begin
		rd_mux = '0;
		case (reg_addr)
			REG_CFG: rd_mux[CFG_CMD_COMPLETE_IRQ_EN_BIT] = cmd_complete_irq_en_ff;
			REG_ERR_CFG: rd_mux[1:0] = {double_fault_irq_en_ff, single_fault_irq_en_ff};
			REG_STAT:
			begin
				rd_mux[STAT_CMD_COMPLETE_FLAG_BIT] = cmd_complete_flag_ff;
				rd_mux[STAT_ACC_BIT] = acc_ff;
				rd_mux[1:0] = error_status_bits_ff;
			end
			REG_ERR_STAT: rd_mux[1:0] = {double_fault_flag_ff, single_fault_flag_ff};
			REG_SEC: rd_mux[7:0] = sec_ff;
			REG_CMD: rd_mux[7:0] = cmd_ff;
			default: rd_mux = '0;
		endcase
	end

	// presented keys are write-only so they cannot be read back
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_ff <= '0;
		else
			rdata_ff <= reg_rd ? rd_mux : '0;
	end

	fis_irq_gate #(.N(1)) u_cmd_irq (
		.flags(cmd_complete_flag_ff),
		.enables(cmd_complete_irq_en_ff),
		.irq(irq_cmd)
	); // see R1

	fis_irq_gate #(.N(2)) u_err_irq (
		.flags({double_fault_flag_ff, single_fault_flag_ff}),
		.enables({double_fault_irq_en_ff, single_fault_irq_en_ff}),
		.irq(irq_err)
	); // see R4

	assign reg_rdata = rdata_ff;
	assign op_start = go_op;
	assign op_cmd = cmd_ff;
	assign wake_req = irq_cmd; // see R6
	assign stop_ack = stop_req && cmd_complete_flag_ff && (state_ff == ST_IDLE); // see R7
	assign read_blank = key_fin; // see R14
	assign sec_state = sec_ff[1:0];
	assign dbg_all_en = (sec_ff[1:0] == SEC_UNSECURED); // see R18

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_key_good;
		go_key ##1 key_match;
	endsequence

	sequence s_key_bad;
		go_key ##1 !key_match;
	endsequence

	a_cmd_irq_level: // see R1 see R19
	assert property (irq_cmd == (cmd_complete_flag_ff && cmd_complete_irq_en_ff))
		else $error("command irq does not follow flag and enable");
	a_err_irq_level: // see R4 see R19
	assert property (irq_err == ((double_fault_flag_ff && double_fault_irq_en_ff)
		|| (single_fault_flag_ff && single_fault_irq_en_ff)))
		else $error("error irq does not follow fault flags");
	a_double_flag_set: // see R2
	assert property (ecc_dbl_evt |=> double_fault_flag_ff)
		else $error("double fault flag not set");
	a_single_flag_set: // see R3
	assert property (ecc_sgl_evt |=> single_fault_flag_ff)
		else $error("single fault flag not set");
	a_stop_held_off: // see R7
	assert property (stop_req && !cmd_complete_flag_ff |-> !stop_ack)
		else $error("stop granted during a command");
	a_sec_load: // see R8
	assert property (rs_done && !rs_bad |=> sec_ff == $past(nvm_rdata[7:0]))
		else $error("security byte not loaded at reset");
	a_sec_stable_run: // see R9 see R16
	assert property (!rs_done && !key_fin && !eva_unsec |=> $stable(sec_ff))
		else $error("security changed without cause");
	a_key_unsecures: // see R12
	assert property (s_key_good |=> sec_ff[1:0] == SEC_UNSECURED
		&& cmd_complete_flag_ff)
		else $error("matching keys did not unsecure");
	a_key_lockout: // see R15
	assert property (key_lock_ff && launch && is_key |=> !read_blank
		&& acc_ff)
		else $error("key verify accepted after mismatch");
	a_key_miss_lock: // see R15
	assert property (s_key_bad |=> key_lock_ff && acc_ff && cmd_complete_flag_ff)
		else $error("mismatched keys did not lock verify");
	a_blank_window: // see R14
	assert property (go_key |=> read_blank ##1 !read_blank)
		else $error("flash read blanking wrong");
	a_cmd_complete_flag_in_reset_seq: // see R20
	assert property (state_ff inside {ST_RS_REQ, ST_RS_CAP} |-> !cmd_complete_flag_ff)
		else $error("complete flag set during reset sequence");
	a_reset_fault: // see R21
	assert property (rs_done && rs_bad |=> error_status_bits_ff == ERROR_STATUS_BITS_BOTH
		&& sec_ff == SEC_FALLBACK)
		else $error("reset fault fallback missing");
	a_erase_unsecure: // see R18
	assert property (eva_unsec |=> dbg_all_en)
		else $error("erased special mode did not unsecure");
endmodule : fis_flash_ctl

// ==== bench/fis_flash_model.sv ====
`timescale 1ns/100ps
module fis_flash_model
	import fis_pkg::*;
#(
	parameter logic [63:0] KEYS = 64'h1111_2222_3333_4444,
	parameter logic [7:0] SEC_BYTE = 8'h80
)
(
	input wire logic mclk,
	input wire logic nvm_rd,
	input wire logic [17:0] nvm_addr,
	output logic [15:0] nvm_rdata,
	output logic nvm_ecc_dbl,
	input wire logic dbl_in,
	input wire logic op_start,
	output logic op_done
);
	logic [1:0] cnt_ff = 2'h0;
	logic busy_ff = 1'b0;
	initial
	begin
		nvm_rdata = 16'h0000;
		nvm_ecc_dbl = 1'b0;
		op_done = 1'b0;
	end
	always @(posedge mclk)
	begin
		nvm_ecc_dbl <= nvm_rd & dbl_in;
		// idle bus keeps toggling so stale data never looks valid
		if (!nvm_rd)
			nvm_rdata <= ~nvm_rdata;
		else if (nvm_addr == ADDR_SEC_BYTE - 18'h1)
			nvm_rdata <= {8'h00, SEC_BYTE};
		else
			nvm_rdata <= KEYS[63 - 8 * nvm_addr[2:0] -: 16];
		op_done <= busy_ff && cnt_ff == 2'h3;
		cnt_ff <= busy_ff ? cnt_ff + 2'h1 : 2'h0;
		if (op_start)
			busy_ff <= 1'b1;
		else if (cnt_ff == 2'h3)
			busy_ff <= 1'b0;
	end
endmodule : fis_flash_model

// ==== bench/tb_fis_flash_ctl.sv ====
`timescale 1ns/100ps
module tb_fis_flash_ctl;
	import fis_pkg::*;
	localparam logic [63:0] KEYS = 64'h1111_2222_3333_4444;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata, nvm_rdata;
	logic [17:0] nvm_addr;
	logic nvm_rd, nvm_ecc_dbl, op_start, op_done, stop_ack;
	logic ecc_sgl_evt = 1'b0;
	logic ecc_dbl_evt = 1'b0;
	logic [1:0] op_err = 2'h0;
	logic op_erased = 1'b0;
	logic ssc_mode = 1'b0;
	logic stop_req = 1'b0;
	logic dbl_in = 1'b0;
	logic irq_cmd, irq_err, wake_req, read_blank, dbg_all_en;
	logic [7:0] op_cmd;
	logic [1:0] sec_state;
	int err_total = 0;
	int tests_run = 0;
	always #4 mclk = ~mclk;
	fis_flash_ctl fis_flash_ctl_i (.mclk(mclk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .nvm_rd(nvm_rd),
		.nvm_addr(nvm_addr), .nvm_rdata(nvm_rdata),
		.nvm_ecc_dbl(nvm_ecc_dbl), .ecc_sgl_evt(ecc_sgl_evt),
		.ecc_dbl_evt(ecc_dbl_evt), .op_start(op_start), .op_cmd(op_cmd),
		.op_done(op_done), .op_err(op_err), .op_erased(op_erased),
		.ssc_mode(ssc_mode), .stop_req(stop_req), .stop_ack(stop_ack),
		.irq_cmd(irq_cmd), .irq_err(irq_err), .wake_req(wake_req),
		.read_blank(read_blank), .sec_state(sec_state),
		.dbg_all_en(dbg_all_en));
	fis_flash_model #(.KEYS(KEYS)) fis_flash_model_i (.mclk(mclk),
		.nvm_rd(nvm_rd), .nvm_addr(nvm_addr), .nvm_rdata(nvm_rdata),
		.nvm_ecc_dbl(nvm_ecc_dbl), .dbl_in(dbl_in), .op_start(op_start),
		.op_done(op_done));
	task automatic finish_test;
		if (err_total == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		tests_run++;
		if (g !== e)
		begin
			$display("[ERR] %s exp %h got %h", nm, e, g);
			err_total++;
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rdc(input logic [3:0] a, input logic [15:0] e,
		input string nm);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		chk(nm, e, reg_rdata);
	endtask : rdc
	task automatic ev(input logic d, input logic s);
		@(posedge mclk);
		ecc_dbl_evt <= d;
		ecc_sgl_evt <= s;
		@(posedge mclk);
		ecc_dbl_evt <= 1'b0;
		ecc_sgl_evt <= 1'b0;
		#1;
	endtask : ev
	task automatic launch(input logic [7:0] c);
		wr(REG_CMD, {8'h00, c});
		wr(REG_STAT, 16'h0080);
	endtask : launch
	task automatic set_keys(input logic [63:0] k);
		for (int i = 0; i < 4; i++)
			wr(REG_KEY0 + 4'(i), k[63 - 16 * i -: 16]);
	endtask : set_keys
	task automatic wait_ack;
		int n;
		n = 0;
		while (stop_ack !== 1'b1 && n < 20)
		begin
			@(posedge mclk);
			#1;
			n++;
		end
		if (stop_ack !== 1'b1)
		begin
			$display("[ERR] stop_ack exp 1 got %b", stop_ack);
			err_total++;
			finish_test();
		end
	endtask : wait_ack
	task automatic do_reset(input logic dbl);
		@(posedge mclk);
		rst_n <= 1'b0;
		dbl_in <= dbl;
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		// command write inside the load sequence must be dropped
		wr(REG_CMD, 16'h0002);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= REG_STAT;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		chk("flag in seq", 16'h0000, reg_rdata & 16'h0080);
		repeat (10) @(posedge mclk);
		#1;
		chk("op_cmd", 16'h0000, {8'h00, op_cmd});
		rdc(REG_STAT, dbl ? 16'h0083 : 16'h0080, "stat");
		rdc(REG_SEC, dbl ? 16'h00FF : 16'h0080, "sec");
		dbl_in <= 1'b0;
	endtask : do_reset
	task automatic t_irq_cmd;
		wr(REG_CFG, 16'h0080);
		chk("irq_cmd", 16'h0001, {15'h0, irq_cmd});
		chk("wake_req", 16'h0001, {15'h0, wake_req});
		wr(REG_CFG, 16'h0000);
		chk("irq_cmd off", 16'h0000, {15'h0, irq_cmd});
	endtask : t_irq_cmd
	task automatic t_faults;
		wr(REG_ERR_CFG, 16'h0001);
		ev(1'b1, 1'b0);
		rdc(REG_ERR_STAT, 16'h0002, "err_stat dbl");
		chk("irq_err masked", 16'h0000, {15'h0, irq_err});
		ev(1'b0, 1'b1);
		rdc(REG_ERR_STAT, 16'h0003, "err_stat sgl");
		chk("irq_err sgl", 16'h0001, {15'h0, irq_err});
		wr(REG_ERR_STAT, 16'h0001);
		chk("irq_err clr", 16'h0000, {15'h0, irq_err});
		wr(REG_ERR_CFG, 16'h0002);
		chk("irq_err dbl", 16'h0001, {15'h0, irq_err});
		wr(REG_ERR_STAT, 16'h0002);
		chk("irq_err off", 16'h0000, {15'h0, irq_err});
		// clear and fault in one cycle: the fault must win
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= REG_ERR_STAT;
		reg_wdata <= 16'h0001;
		ecc_sgl_evt <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		ecc_sgl_evt <= 1'b0;
		#1;
		rdc(REG_ERR_STAT, 16'h0001, "err_stat set wins");
	endtask : t_faults
	task automatic t_op_stop;
		@(posedge mclk);
		stop_req <= 1'b1;
		op_err <= 2'h1;
		@(posedge mclk);
		#1;
		chk("stop idle", 16'h0001, {15'h0, stop_ack});
		launch(8'h02);
		chk("stop busy", 16'h0000, {15'h0, stop_ack});
		wait_ack();
		rdc(REG_STAT, 16'h0081, "stat done");
		chk("dbg off", 16'h0000, {15'h0, dbg_all_en});
		stop_req <= 1'b0;
		op_err <= 2'h0;
	endtask : t_op_stop
	task automatic t_keys;
		set_keys(KEYS ^ 64'h1);
		launch(CMD_VERIFY_KEY);
		chk("blank", 16'h0001, {15'h0, read_blank});
		rdc(REG_STAT, 16'h00A0, "stat miss");
		rdc(REG_SEC, 16'h0080, "sec miss");
		set_keys(KEYS);
		launch(CMD_VERIFY_KEY);
		chk("no blank", 16'h0000, {15'h0, read_blank});
		rdc(REG_STAT, 16'h00A0, "stat refused");
		chk("sec refused", 16'h0000, {14'h0, sec_state});
		do_reset(1'b0);
		set_keys(KEYS);
		launch(CMD_VERIFY_KEY);
		rdc(REG_STAT, 16'h0080, "stat match");
		rdc(REG_SEC, 16'h0082, "sec match");
		chk("dbg key", 16'h0001, {15'h0, dbg_all_en});
	endtask : t_keys
	task automatic t_ssc;
		do_reset(1'b0);
		@(posedge mclk);
		ssc_mode <= 1'b1;
		op_erased <= 1'b1;
		stop_req <= 1'b1;
		launch(CMD_ERASE_VERIFY_ALL);
		wait_ack();
		@(posedge mclk);
		#1;
		chk("sec ssc", 16'h0002, {14'h0, sec_state});
		chk("dbg ssc", 16'h0001, {15'h0, dbg_all_en});
		ssc_mode <= 1'b0;
		op_erased <= 1'b0;
		stop_req <= 1'b0;
	endtask : t_ssc
	initial
	begin
		do_reset(1'b0);
		t_irq_cmd();
		t_faults();
		t_op_stop();
		t_keys();
		t_ssc();
		do_reset(1'b1);
		finish_test();
	end
endmodule : tb_fis_flash_ctl
